// ==== sim/rio_cpu_model.sv ====
// Processor model: drives bus cycles and sees the shared request line
`timescale 1ns/1ns
module rio_cpu_model (
  input  wire logic              sys_clk,   // System clock
  input  wire logic [7:0]        data_out,  // Device read data
  input  wire logic              data_oe,   // Device drives data bus
  input  wire logic              irq_n_out, // Request pin level
  input  wire logic              irq_n_oe,  // Request pin drive
  output rio_pkg::rio_bus_t      bus_out,   // Selects, address, data
  output logic                   irq_line   // Resolved request wire
);
  ////////////////////////////////////////////////////////////////////////////
  // Pull-up on the shared request wire
  assign irq_line = irq_n_oe ? irq_n_out : 1'h1;

  // Idle bus: chip deselected, other fields zero
  initial bus_out = '{cs_high: 1'h0, cs_low_n: 1'h1, default: '0};

  ////////////////////////////////////////////////////////////////////////////
  // One bus cycle: present at an edge, taken at the next, read in its wake
  // Edge control writes carry don't-care data flag reads clear edge
  task automatic access(input rio_pkg::rio_bus_t b, output logic oe,
                        output logic [7:0] d);
    rio_pkg::rio_bus_t idle;
    idle          = ~b;
    idle.cs_high  = 1'h0;
    idle.cs_low_n = 1'h1;
    @(posedge sys_clk);
    bus_out <= b;
    @(posedge sys_clk);
    bus_out <= idle;
    @(negedge sys_clk);
    oe = data_oe;
    // Undriven bus reads back as a changed pattern
    d  = data_oe ? data_out : ~data_out;
  endtask : access
endmodule : rio_cpu_model

// ==== sim/rio_select_tb.sv ====
// Self-checking bench for the select, flag and request block
`timescale 1ns/1ns
module rio_select_tb;
  // One table row: bus cycle beside the expected answer
  typedef struct packed {
    logic       csh;   // High select
    logic       csl_n; // Low select
    logic       rs;    // RAM versus I/O
    logic       rd;    // Read
    logic [6:0] a;     // Address
    logic [7:0] wd;    // Write data
    logic       oe;    // Expected drive
    logic [7:0] ex;    // Expected data
  } rio_row_t;
  localparam rio_row_t ROWS [0:16] = '{
    '{1'h1, 1'h0, 1'h0, 1'h0, 7'h7f, 8'h5a, 1'h0, 8'h00},
    '{1'h1, 1'h0, 1'h0, 1'h0, 7'h00, 8'hc3, 1'h0, 8'h00},
    '{1'h1, 1'h0, 1'h0, 1'h0, 7'h04, 8'h77, 1'h0, 8'h00},
    '{1'h1, 1'h0, 1'h1, 1'h0, 7'h00, 8'ha5, 1'h0, 8'h00},
    '{1'h1, 1'h0, 1'h1, 1'h0, 7'h01, 8'hff, 1'h0, 8'h00},
    '{1'h1, 1'h0, 1'h1, 1'h0, 7'h02, 8'h3c, 1'h0, 8'h00},
    '{1'h1, 1'h0, 1'h1, 1'h0, 7'h03, 8'h0f, 1'h0, 8'h00},
    '{1'h0, 1'h0, 1'h1, 1'h0, 7'h00, 8'h11, 1'h0, 8'h00},
    '{1'h1, 1'h1, 1'h1, 1'h0, 7'h02, 8'h22, 1'h0, 8'h00},
    '{1'h1, 1'h0, 1'h1, 1'h1, 7'h00, 8'h00, 1'h1, 8'ha5},
    '{1'h1, 1'h0, 1'h1, 1'h1, 7'h01, 8'h00, 1'h1, 8'hff},
    '{1'h1, 1'h0, 1'h1, 1'h1, 7'h02, 8'h00, 1'h1, 8'h3c},
    '{1'h1, 1'h0, 1'h1, 1'h1, 7'h03, 8'h00, 1'h1, 8'h0f},
    '{1'h1, 1'h0, 1'h0, 1'h1, 7'h7f, 8'h00, 1'h1, 8'h5a},
    '{1'h1, 1'h0, 1'h0, 1'h1, 7'h00, 8'h00, 1'h1, 8'hc3},
    '{1'h1, 1'h0, 1'h0, 1'h1, 7'h04, 8'h00, 1'h1, 8'h77},
    '{1'h0, 1'h0, 1'h1, 1'h1, 7'h00, 8'h00, 1'h0, 8'h00}};

  logic              sys_clk;      // 10 MHz clock
  logic              sys_rst;      // Async reset
  rio_pkg::rio_bus_t bus;          // Bus from the processor model
  logic [7:0]        port_a_pins;  // Port A pins
  logic [7:0]        timer_count;  // Timer count
  logic              timer_expire; // Timeout pulse
  logic [7:0]        data_out;     // Read data
  logic              data_oe;      // Data drive
  logic              irq_n_out;    // Request level
  logic              irq_n_oe;     // Request drive
  logic              irq_line;     // Resolved request
  logic              timer_load;   // Timer write pulse
  logic [7:0]        timer_data;   // Timer start value
  logic [1:0]        timer_prescale; // Prescale choice
  logic [7:0]        pa_lat;       // Port A latch
  logic [7:0]        pa_dir;       // Port A direction
  logic [7:0]        pb_lat;       // Port B latch
  logic [7:0]        pb_dir;       // Port B direction
  logic              rd_oe;        // Last cycle drive
  logic [7:0]        rd_d;         // Last cycle data
  int                errors;       // Mismatches
  int                checked;      // Comparisons

  ////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  initial sys_clk = 1'h0;
  always #50 sys_clk = ~sys_clk;

  rio_select i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_in(bus),
    .port_a_pins(port_a_pins), .timer_count(timer_count), .timer_expire(timer_expire),
    .data_out(data_out), .data_oe(data_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .timer_load(timer_load), .timer_data(timer_data), .timer_prescale(timer_prescale),
    .port_a_output_latch(pa_lat), .port_a_direction(pa_dir),
    .port_b_output_latch(pb_lat), .port_b_direction(pb_dir));

  rio_cpu_model i_cpu (.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .bus_out(bus), .irq_line(irq_line));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] ex, input string what);
    checked++;
    if (got !== ex)
    begin
      errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, ex);
    end
  endtask : chk

  // Selected cycle through the processor model
  task automatic op(input logic rs, input logic rd, input logic [6:0] a, input logic [7:0] wd);
    i_cpu.access('{1'h1, 1'h0, rs, rd, a, wd}, rd_oe, rd_d);
  endtask : op

  task automatic flags(input logic [7:0] ex);
    op(1'h1, 1'h1, 7'h05, 8'h00);
    chk(rd_d, ex, "flags");
  endtask : flags

  task automatic pin7(input logic v);
    @(posedge sys_clk);
    port_a_pins[7] <= v;
    repeat (8) @(posedge sys_clk);
  endtask : pin7

  task automatic expire;
    @(posedge sys_clk);
    timer_expire <= 1'h1;
    @(posedge sys_clk);
    timer_expire <= 1'h0;
    repeat (3) @(posedge sys_clk);
  endtask : expire

  task automatic finish_test;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // Watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    $display("BAD %0t watchdog", $time);
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    errors = 0;
    checked = 0;
    sys_rst = 1'h1;
    port_a_pins = 8'hff;
    timer_count = 8'h00;
    timer_expire = 1'h0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(negedge sys_clk);
    chk({3'h0, data_oe, irq_n_oe, timer_prescale, timer_load}, 8'h00, "reset outs");
    chk(pa_lat | pa_dir | pb_lat | pb_dir, 8'h00, "reset ports");
    repeat (4) @(posedge sys_clk);
    op(1'h1, 1'h1, 7'h05, 8'h00);
    // Table of plain accesses
    foreach (ROWS[i])
    begin
      i_cpu.access('{ROWS[i].csh, ROWS[i].csl_n, ROWS[i].rs, ROWS[i].rd, ROWS[i].a,
                     ROWS[i].wd}, rd_oe, rd_d);
      chk({7'h00, rd_oe}, {7'h00, ROWS[i].oe}, "drive");
      if (ROWS[i].oe)
        chk(rd_d, ROWS[i].ex, "row data");
    end
    // Edge: positive, enabled, line set as output
    op(1'h1, 1'h0, 7'h07, 8'hff);
    pin7(1'h0);
    flags(8'h00);
    pin7(1'h1);
    chk({7'h00, irq_line}, 8'h00, "edge request");
    flags(8'h40);
    repeat (3) @(posedge sys_clk);
    chk({7'h00, irq_line}, 8'h01, "edge release");
    op(1'h1, 1'h0, 7'h06, 8'h00);
    pin7(1'h0);
    chk({7'h00, irq_line}, 8'h00, "neg request");
    flags(8'h40);
    op(1'h1, 1'h0, 7'h05, 8'h00);
    pin7(1'h1);
    chk({7'h00, irq_line}, 8'h01, "edge masked");
    flags(8'h40);
    // Timer writes with every prescale choice
    for (int p = 0; p < 4; p++)
    begin
      op(1'h1, 1'h0, 7'h1c | 7'(p), 8'h34);
      chk({7'h00, timer_load}, 8'h01, "load");
      chk({6'h00, timer_prescale}, 8'(p), "prescale");
      chk(timer_data, 8'h34, "start");
    end
    expire();
    chk({7'h00, irq_line}, 8'h00, "timer request");
    flags(8'h80);
    flags(8'h80);
    @(posedge sys_clk);
    timer_count <= 8'h9c;
    op(1'h1, 1'h1, 7'h04, 8'h00);
    chk(rd_d, 8'h9c, "count");
    flags(8'h00);
    op(1'h1, 1'h1, 7'h0c, 8'h00);
    expire();
    chk({7'h00, irq_line}, 8'h00, "read enable");
    op(1'h1, 1'h0, 7'h14, 8'h10);
    repeat (2) @(posedge sys_clk);
    chk({7'h00, irq_line}, 8'h01, "write clears");
    expire();
    chk({7'h00, irq_line}, 8'h01, "timer masked");
    flags(8'h80);
    op(1'h1, 1'h1, 7'h04, 8'h00);
    flags(8'h00);
    // Timer read in the very cycle of timeout
    fork
      op(1'h1, 1'h1, 7'h04, 8'h00);
      expire();
    join
    pin7(1'h0);
    pin7(1'h1);
    flags(8'hc0);
    // Second reset in mid-run
    @(posedge sys_clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(negedge sys_clk);
    chk(pa_dir | pb_lat | {6'h00, timer_prescale}, 8'h00, "rerun reset");
    repeat (4) @(posedge sys_clk);
    op(1'h1, 1'h1, 7'h05, 8'h00);
    pin7(1'h0);
    chk({7'h00, irq_line}, 8'h01, "reset masked");
    flags(8'h40);
    finish_test();
  end
endmodule : rio_select_tb

// ==== verilog/rio_pkg.sv ====
// Constants, carrier types and decode helper for the RAM, I/O and timer select block
package rio_pkg;

  localparam int          DATA_W       = 8;       // Data bus width
  localparam int          ADDR_W       = 7;       // Address lines A0..A6
  localparam int          RAM_DEPTH    = 128;     // RAM bytes
  localparam int          A0_BIT       = 0;       // Register select low
  localparam int          A1_BIT       = 1;       // Register select high
  localparam int          A2_BIT       = 2;       // Timer versus ports
  localparam int          A3_BIT       = 3;       // Timer interrupt enable
  localparam int          A4_BIT       = 4;       // Timer write versus edge control
  localparam int          TFLAG_BIT    = 7;       // Timer expiry flag position
  localparam int          EFLAG_BIT    = 6;       // Edge flag position
  localparam int          TOP_LINE     = 7;       // Edge-sensed port A line
  localparam logic [1:0]  PA_LATCH     = 2'h0;    // Port A output latch
  localparam logic [1:0]  PA_DIR       = 2'h1;    // Port A direction
  localparam logic [1:0]  PB_LATCH     = 2'h2;    // Port B output latch
  localparam logic [1:0]  PB_DIR       = 2'h3;    // Port B direction
  localparam logic [1:0]  PRE_DIV1     = 2'h0;    // Divide by 1
  localparam logic [1:0]  PRE_DIV8     = 2'h1;    // Divide by 8
  localparam logic [1:0]  PRE_DIV64    = 2'h2;    // Divide by 64
  localparam logic [1:0]  PRE_DIV1024  = 2'h3;    // Divide by 1024
  localparam logic [7:0]  RST_BYTE     = 8'h00;   // Reset value of byte registers
  localparam logic [1:0]  RST_PRESCALE = 2'h0;    // Reset prescale choice
  localparam logic        RST_EDGE_EN  = 1'b0;    // Edge interrupt off at reset
  localparam logic        RST_EDGE_POS = 1'b0;    // Negative edge at reset
  localparam logic        RST_TIMER_EN = 1'b0;    // Timer interrupt off at reset
  localparam logic [5:0]  FLAG_PAD     = 6'h00;   // Empty flag bits

  // One bus cycle as seen on the pins
  typedef struct packed {
    logic              cs_high;            // chip_select_high
    logic              cs_low_n;           // chip_select_low_n
    logic              ram_io_select_n;    // Low selects RAM
    logic              rd_wr_n;            // High reads, low writes
    logic [ADDR_W-1:0] addr;               // A6..A0
    logic [DATA_W-1:0] wdata;              // Write data
  } rio_bus_t;

  // Decoded access kinds
  typedef struct packed {
    logic ram;        // RAM access
    logic port;       // Port register access
    logic twrite;     // Timer write
    logic tread;      // Timer count read
    logic fread;      // Flag register read
    logic edge_wr;    // Edge control write
  } rio_sel_t;

  // Steers one bus cycle to its target
  function automatic rio_sel_t rio_decode(input rio_bus_t b);
    logic     chip;
    logic     io;
    rio_sel_t s;
    chip     = b.cs_high && !b.cs_low_n;
    io       = chip && b.ram_io_select_n;
    s.ram    = chip && !b.ram_io_select_n;
    s.port   = io && !b.addr[A2_BIT];
    s.twrite = io && b.addr[A2_BIT] && !b.rd_wr_n && b.addr[A4_BIT];
    s.edge_wr = io && b.addr[A2_BIT] && !b.rd_wr_n && !b.addr[A4_BIT];
    s.tread  = io && b.addr[A2_BIT] && b.rd_wr_n && !b.addr[A0_BIT];
    s.fread  = io && b.addr[A2_BIT] && b.rd_wr_n && b.addr[A0_BIT];
    return s;
  endfunction : rio_decode

endpackage : rio_pkg

// ==== verilog/rio_ram.sv ====
// Byte-wide flip-flop RAM with combinational read
`timescale 1ns/1ns
module rio_ram (
  input  wire logic                        sys_clk, // System clock
  input  wire logic                        wr_en,   // Write strobe
  input  wire logic [rio_pkg::ADDR_W-1:0]  addr,    // Byte index
  input  wire logic [rio_pkg::DATA_W-1:0]  wdata,   // Write data
  output logic      [rio_pkg::DATA_W-1:0]  rdata    // Read data
);

  logic [rio_pkg::DATA_W-1:0] mem_r [rio_pkg::RAM_DEPTH]; // Storage

  // Write port; contents are undefined until written
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem_r[addr] <= wdata;
    end
  end

  assign rdata = mem_r[addr];

endmodule : rio_ram

// ==== verilog/rio_select.sv ====
// Access decode, port registers, interrupt flags and open-drain request
`timescale 1ns/1ns
module rio_select (
  input  wire logic                       sys_clk,         // System clock, 10 MHz
  input  wire logic                       sys_rst,         // Async reset, high
  input  wire rio_pkg::rio_bus_t          bus_in,          // Selects, address, data
  input  wire logic [7:0]                 port_a_pins,     // Port A pin levels
  input  wire logic [7:0]                 timer_count,     // Count from timer core
  input  wire logic                       timer_expire,    // Timeout pulse
  output logic      [7:0]                 data_out,        // Read data
  output logic                            data_oe,         // Data bus drive
  output logic                            irq_n_out,       // Request pin level
  output logic                            irq_n_oe,        // Request pin drive
  output logic                            timer_load,      // Timer write pulse
  output logic      [7:0]                 timer_data,      // Timer start value
  output logic      [1:0]                 timer_prescale,  // Prescale choice
  output logic      [7:0]                 port_a_output_latch, // Port A latch
  output logic      [7:0]                 port_a_direction,    // Port A direction
  output logic      [7:0]                 port_b_output_latch, // Port B latch
  output logic      [7:0]                 port_b_direction     // Port B direction
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  rio_pkg::rio_sel_t sel;         // Decoded access
  logic [7:0]  pa_sync;           // Synchronised port A pins
  logic [7:0]  ram_rdata;         // RAM read byte
  logic        edge_hit;          // Active transition seen
  logic        irq_want;          // Some enabled flag set
  logic [1:0]  reg_idx;           // Port register index
  logic        pa7_prev_r;        // Previous top-line level
  logic        pa7_prev_nxt;
  logic        tflag_r;           // Timer expiry flag
  logic        tflag_nxt;
  logic        eflag_r;           // Edge flag
  logic        eflag_nxt;
  logic        timer_en_r;        // Timer interrupt enable
  logic        timer_en_nxt;
  logic        edge_en_r;         // Edge interrupt enable
  logic        edge_en_nxt;
  logic        edge_pos_r;        // Positive edge chosen
  logic        edge_pos_nxt;
  logic [7:0]  rdata_r;           // Registered read data
  logic [7:0]  rdata_nxt;
  logic        oe_r;              // Data bus drive
  logic        oe_nxt;
  logic        irq_oe_r;          // Request drive
  logic        irq_oe_nxt;
  logic        tload_r;           // Timer write pulse
  logic        tload_nxt;
  logic [7:0]  tdata_r;           // Timer start value
  logic [7:0]  tdata_nxt;
  logic [1:0]  pre_r;             // Prescale choice
  logic [1:0]  pre_nxt;
  logic [7:0]  pa_latch_r;        // Port A latch
  logic [7:0]  pa_latch_nxt;
  logic [7:0]  pa_dir_r;          // Port A direction
  logic [7:0]  pa_dir_nxt;
  logic [7:0]  pb_latch_r;        // Port B latch
  logic [7:0]  pb_latch_nxt;
  logic [7:0]  pb_dir_r;          // Port B direction
  logic [7:0]  pb_dir_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and helpers

  // Steers the access by selects, read/write, A0, A2 and A4
  assign sel     = rio_pkg::rio_decode(bus_in);
  assign reg_idx = bus_in.addr[rio_pkg::A1_BIT:rio_pkg::A0_BIT];

  // Port A pins pass two flops before use
  rio_sync #(
    .WIDTH    (8)
  ) u_pa_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .pin_in   (port_a_pins),
    .sync_out (pa_sync)
  );

  // RAM storage
  rio_ram u_ram (
    .sys_clk (sys_clk),
    .wr_en   (sel.ram && !bus_in.rd_wr_n),
    .addr    (bus_in.addr),
    .wdata   (bus_in.wdata),
    .rdata   (ram_rdata)
  );

  // Edge seen on the synchronised top line, direction plays no part
  always_comb
  begin
    if (edge_pos_r)
    begin
      edge_hit = pa_sync[rio_pkg::TOP_LINE] && !pa7_prev_r;
    end
    else
    begin
      edge_hit = !pa_sync[rio_pkg::TOP_LINE] && pa7_prev_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt control

  // Next flag, enable and request values
  always_comb
  begin
    pa7_prev_nxt = pa_sync[rio_pkg::TOP_LINE];
    tflag_nxt    = tflag_r;
    eflag_nxt    = eflag_r;
    timer_en_nxt = timer_en_r;
    edge_en_nxt  = edge_en_r;
    edge_pos_nxt = edge_pos_r;
    // Timer access clears the timer flag
    if (sel.twrite || sel.tread)
    begin
      tflag_nxt    = 1'b0;
      timer_en_nxt = bus_in.addr[rio_pkg::A3_BIT];
    end
    // Timeout wins over a coincident clear
    if (timer_expire)
    begin
      tflag_nxt = 1'b1;
    end
    // Flag read clears the edge flag
    if (sel.fread)
    begin
      eflag_nxt = 1'b0;
    end
    // Edge wins over a coincident clear
    if (edge_hit)
    begin
      eflag_nxt = 1'b1;
    end
    // Edge control write, data ignored
    if (sel.edge_wr)
    begin
      edge_en_nxt  = bus_in.addr[rio_pkg::A1_BIT];
      edge_pos_nxt = bus_in.addr[rio_pkg::A0_BIT];
    end
  end

  // Either enabled flag pulls the request low
  assign irq_want   = (tflag_r && timer_en_r) || (eflag_r && edge_en_r);
  assign irq_oe_nxt = irq_want;

  // Flag and enable registers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pa7_prev_r <= 1'b0;
      tflag_r    <= 1'b0;
      eflag_r    <= 1'b0;
      timer_en_r <= rio_pkg::RST_TIMER_EN;
      edge_en_r  <= rio_pkg::RST_EDGE_EN;
      edge_pos_r <= rio_pkg::RST_EDGE_POS;
      irq_oe_r   <= 1'b0;
    end
    else
    begin
      pa7_prev_r <= pa7_prev_nxt;
      tflag_r    <= tflag_nxt;
      eflag_r    <= eflag_nxt;
      timer_en_r <= timer_en_nxt;
      edge_en_r  <= edge_en_nxt;
      edge_pos_r <= edge_pos_nxt;
      irq_oe_r   <= irq_oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port registers, timer strobes and read data

  // Next register and read values
  always_comb
  begin
    pa_latch_nxt = pa_latch_r;
    pa_dir_nxt   = pa_dir_r;
    pb_latch_nxt = pb_latch_r;
    pb_dir_nxt   = pb_dir_r;
    tload_nxt    = sel.twrite;
    tdata_nxt    = tdata_r;
    pre_nxt      = pre_r;
    rdata_nxt    = rio_pkg::RST_BYTE;
    oe_nxt       = bus_in.rd_wr_n && (sel.ram || sel.port || sel.tread || sel.fread);
    // Port register write
    if (sel.port && !bus_in.rd_wr_n)
    begin
      case (reg_idx)
        rio_pkg::PA_LATCH: pa_latch_nxt = bus_in.wdata;
        rio_pkg::PA_DIR:   pa_dir_nxt   = bus_in.wdata;
        rio_pkg::PB_LATCH: pb_latch_nxt = bus_in.wdata;
        default:           pb_dir_nxt   = bus_in.wdata;
      endcase
    end
    // Timer write takes count and prescale
    if (sel.twrite)
    begin
      tdata_nxt = bus_in.wdata;
      pre_nxt   = reg_idx;
    end
    // Read data selection
    if (sel.ram)
    begin
      rdata_nxt = ram_rdata;
    end
    else if (sel.port)
    begin
      case (reg_idx)
        rio_pkg::PA_LATCH: rdata_nxt = (pa_sync & ~pa_dir_r) | (pa_latch_r & pa_dir_r);
        rio_pkg::PA_DIR:   rdata_nxt = pa_dir_r;
        rio_pkg::PB_LATCH: rdata_nxt = pb_latch_r;
        default:           rdata_nxt = pb_dir_r;
      endcase
    end
    else if (sel.tread)
    begin
      rdata_nxt = timer_count;
    end
    else if (sel.fread)
    begin
      rdata_nxt = {tflag_r, eflag_r, rio_pkg::FLAG_PAD};
    end
  end

  // Port, timer and read registers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pa_latch_r <= rio_pkg::RST_BYTE;
      pa_dir_r   <= rio_pkg::RST_BYTE;
      pb_latch_r <= rio_pkg::RST_BYTE;
      pb_dir_r   <= rio_pkg::RST_BYTE;
      tload_r    <= 1'b0;
      tdata_r    <= rio_pkg::RST_BYTE;
      pre_r      <= rio_pkg::RST_PRESCALE;
      rdata_r    <= rio_pkg::RST_BYTE;
      oe_r       <= 1'b0;
    end
    else
    begin
      pa_latch_r <= pa_latch_nxt;
      pa_dir_r   <= pa_dir_nxt;
      pb_latch_r <= pb_latch_nxt;
      pb_dir_r   <= pb_dir_nxt;
      tload_r    <= tload_nxt;
      tdata_r    <= tdata_nxt;
      pre_r      <= pre_nxt;
      rdata_r    <= rdata_nxt;
      oe_r       <= oe_nxt;
    end
  end

  // Outputs straight from registers; request level is a constant low
  assign data_out            = rdata_r;
  assign data_oe             = oe_r;
  assign irq_n_out           = 1'b0;
  assign irq_n_oe            = irq_oe_r;
  assign timer_load          = tload_r;
  assign timer_data          = tdata_r;
  assign timer_prescale      = pre_r;
  assign port_a_output_latch = pa_latch_r;
  assign port_a_direction    = pa_dir_r;
  assign port_b_output_latch = pb_latch_r;
  assign port_b_direction    = pb_dir_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Flag read answered next cycle
  sequence flag_rd_s;
    sel.fread ##1 oe_r;
  endsequence

  tflag_set_a: assert property (timer_expire |=> tflag_r)
    else $error("timer flag not set on timeout");
  tflag_keep_a: assert property (timer_expire && sel.tread |=> tflag_r)
    else $error("timer flag lost on coincident read");
  tflag_clr_a: assert property ((sel.tread || sel.twrite) && !timer_expire |=> !tflag_r)
    else $error("timer flag not cleared by timer access");
  eflag_clr_a: assert property (sel.fread && !edge_hit |=> !eflag_r)
    else $error("edge flag not cleared by flag read");
  eflag_set_a: assert property (edge_hit |=> eflag_r)
    else $error("edge flag not set on edge");
  flag_read_a: assert property (flag_rd_s |-> rdata_r == {$past(tflag_r), $past(eflag_r),
                                rio_pkg::FLAG_PAD})
    else $error("flag read data wrong");
  timer_read_a: assert property (sel.tread |=> oe_r && rdata_r == $past(timer_count))
    else $error("timer count not returned");
  irq_drive_a: assert property ((tflag_r && timer_en_r) || (eflag_r && edge_en_r)
                                |=> irq_n_oe)
    else $error("request not driven");
  irq_release_a: assert property (!(tflag_r && timer_en_r) && !(eflag_r && edge_en_r)
                                  |=> !irq_n_oe)
    else $error("request not released");
  edge_cfg_a: assert property (sel.edge_wr |=> edge_en_r == $past(bus_in.addr[1])
                               && edge_pos_r == $past(bus_in.addr[0]))
    else $error("edge control not taken");
  timer_en_a: assert property (sel.twrite |=> timer_load && timer_en_r ==
                               $past(bus_in.addr[3]) && pre_r == $past(reg_idx))
    else $error("timer write fields not taken");
  reset_edge_a: assert property (@(posedge sys_clk) $fell(sys_rst) |->
                                 !edge_en_r && !edge_pos_r)
    else $error("edge control not reset");

endmodule : rio_select

// ==== verilog/rio_sync.sv ====
// Two-flop synchroniser for pin levels
`timescale 1ns/1ns
module rio_sync #(
  parameter int WIDTH = 8                  // Bits synchronised
) (
  input  wire logic             sys_clk,   // System clock
  input  wire logic             sys_rst,   // Async reset, high
  input  wire logic [WIDTH-1:0] pin_in,    // Raw pin levels
  output logic      [WIDTH-1:0] sync_out   // Synchronised levels
);

  logic [WIDTH-1:0] meta_r;   // First stage, read only by second
  logic [WIDTH-1:0] meta_nxt; // First stage next
  logic [WIDTH-1:0] sync_r;   // Second stage
  logic [WIDTH-1:0] sync_nxt; // Second stage next

  // Next values of both stages
  always_comb
  begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
  end

  // Stage registers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule : rio_sync
